// ### hw/rxp_pkg.sv
// Constants and types for the receive-port status and frame-handling register group
package rxp_pkg;
  // Register offsets
  localparam logic [7:0] MAILBOX_A_ADDR = 8'h78;
  localparam logic [7:0] MAILBOX_B_ADDR = 8'h79;
  localparam logic [7:0] ERR_FLAGS_ADDR = 8'h7A;
  localparam logic [7:0] ERR_COUNT_ADDR = 8'h7B;
  localparam logic [7:0] FRAME_CFG_ADDR = 8'h7C;
  // Values after reset, and the tally ceiling
  localparam logic [7:0] MAILBOX_A_RST  = 8'h00;
  localparam logic [7:0] MAILBOX_B_RST  = 8'h01;
  localparam logic [7:0] FRAME_CFG_RST  = 8'h00;
  localparam logic [7:0] COUNT_MAX      = 8'hFF;
  // Flag positions
  localparam int LEN_FLAG_BIT    = 3;
  localparam int CKSUM_FLAG_BIT  = 2;
  localparam int MULTI_FLAG_BIT  = 1;
  localparam int SINGLE_FLAG_BIT = 0;
  // Frame config field positions
  localparam int RED_HI_BIT      = 7;
  localparam int RED_LO_BIT      = 6;
  localparam int PAR_TRUNC_BIT   = 5;
  localparam int LINE_TRUNC_BIT  = 4;
  localparam int FRAME_TRUNC_BIT = 3;
  localparam int LV_INV_BIT      = 1;
  localparam int FV_INV_BIT      = 0;
  // Ten-bit reduction codes
  localparam logic [1:0] RED_NORMAL = 2'h0;
  localparam logic [1:0] RED_UPPER  = 2'h2;
  localparam logic [1:0] RED_LOWER  = 2'h3;
  // Header check column code for each of the 24 header bits
  localparam logic [23:0][5:0] HDR_COL = {
    6'h3B, 6'h37, 6'h2F, 6'h1F, 6'h38, 6'h34, 6'h32, 6'h31,
    6'h2C, 6'h2A, 6'h29, 6'h26, 6'h25, 6'h23, 6'h1C, 6'h1A,
    6'h19, 6'h16, 6'h15, 6'h13, 6'h0E, 6'h0D, 6'h0B, 6'h07};
  typedef enum logic [1:0] {RXP_IDLE, RXP_FWD, RXP_DROP} rxp_frame_t;
endpackage

// ### hw/rxp_port.sv
// Receive-port register group, header check, frame handling and video FIFO
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Video FIFO; count kept in a register so full and empty are exact
module rxp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } rxp_fifo_t;
  rxp_fifo_t st, next_st;
  logic push, pop;

  // Handshakes and storage update
  always_comb begin
    next_st  = st;
    in_ready  = (st.cnt != (AW+1)'(DEPTH));
    out_valid = (st.cnt != '0);
    out_data  = st.mem[st.rd];
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top of the receive port
module rxp_port #(
  parameter int LEN_W = 16,
  parameter int DEPTH = 16
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA,
  input  wire logic        LOCK,
  input  wire logic [1:0]  PASS_THRESHOLD,
  input  wire logic        RAW_MODE,
  input  wire logic        RAW10_MODE,
  input  wire logic        RAW_VALID,
  input  wire logic        RAW_LV,
  input  wire logic        RAW_FV,
  input  wire logic [9:0]  RAW_DATA,
  output logic             RAW_READY,
  input  wire logic        PARITY_ERR,
  input  wire logic        HDR_VALID,
  input  wire logic [23:0] HDR_WORD,
  input  wire logic [5:0]  HDR_ECC,
  input  wire logic        PKT_DONE,
  input  wire logic        PKT_LEN_ERR,
  input  wire logic        PKT_PAYLOAD_CHECK_FAIL_FLAG,
  output logic             HDR_OUT_VALID,
  output logic [23:0]      HDR_OUT,
  output logic             VID_VALID,
  input  wire logic        VID_READY,
  output logic             VID_FV,
  output logic             VID_LV,
  output logic [9:0]       VID_DATA,
  output logic             PORT_PASS
);
  import rxp_pkg::*;

  typedef struct packed {
    logic [7:0]       mbox_a;
    logic [7:0]       mbox_b;
    logic [7:0]       cfg;
    logic [3:0]       flags;
    logic [7:0]       tally;
    logic             pkt_bad;
    logic [7:0]       rdata;
    logic [23:0]      hdr;
    logic             hdr_valid;
    logic             fv_q;
    logic             lv_q;
    logic [LEN_W-1:0] pix;
    logic [LEN_W-1:0] pix_prev;
    logic [LEN_W-1:0] lines;
    logic [LEN_W-1:0] lines_prev;
    logic             have_line;
    logic             have_frame;
    rxp_frame_t       fstate;
    logic             hold;
    logic [1:0]       good;
    logic             pass;
  } rxp_state_t;
  rxp_state_t st, next_st;

  logic [5:0]  syn;
  logic [23:0] fixed;
  logic        hdr_single, hdr_multi, col_hit;
  logic        fv, lv, fv_rise, fv_fall, lv_fall;
  logic        trunc_par, trunc_line, trunc_frame, trunc_any;
  logic [9:0]  pix_out;
  logic        wr_fire, push, fifo_ready;
  logic        pkt_err, rd_flags, rd_tally;

  // Header check: syndrome, single-bit correction, multi-bit detection
  always_comb begin
    syn     = HDR_ECC;
    col_hit = 1'b0;
    fixed   = HDR_WORD;
    for (int i = 0; i < 24; i++) begin
      if (HDR_WORD[i]) begin
        syn = syn ^ HDR_COL[i];
      end
    end
    for (int i = 0; i < 24; i++) begin
      if (syn == HDR_COL[i]) begin
        col_hit  = 1'b1;
        fixed[i] = ~HDR_WORD[i];
      end
    end
    // A lone syndrome bit means the check bits themselves took the hit
    hdr_single = HDR_VALID && (syn != '0) && (col_hit || ($countones(syn) == 1));
    hdr_multi  = HDR_VALID && (syn != '0) && !hdr_single;
  end

  // Polarity, frame edges, reduction and truncation causes
  always_comb begin
    fv = RAW_FV ^ (RAW_MODE && st.cfg[FV_INV_BIT]);
    lv = RAW_LV ^ (RAW_MODE && st.cfg[LV_INV_BIT]);
    fv_rise = fv && !st.fv_q;
    fv_fall = !fv && st.fv_q;
    lv_fall = !lv && st.lv_q && fv;
    // Reserved reduction code behaves as normal packing
    case (st.cfg[RED_HI_BIT:RED_LO_BIT])
      RED_UPPER: pix_out = RAW10_MODE ? {2'h0, RAW_DATA[9:2]} : RAW_DATA;
      RED_LOWER: pix_out = RAW10_MODE ? {2'h0, RAW_DATA[7:0]} : RAW_DATA;
      default:   pix_out = RAW_DATA;
    endcase
    trunc_par  = st.cfg[PAR_TRUNC_BIT] && PARITY_ERR && fv;
    trunc_line = st.cfg[LINE_TRUNC_BIT] && lv_fall && st.have_line
                 && (st.pix != st.pix_prev);
    // Too many lines shows mid-frame, too few at the frame end
    trunc_frame = st.cfg[FRAME_TRUNC_BIT] && st.have_frame
                  && ((lv_fall && (st.lines >= st.lines_prev))
                  || (fv_fall && (st.lines != st.lines_prev)));
    trunc_any = trunc_par || trunc_line || trunc_frame;
    wr_fire   = RAW_VALID && lv && (st.fstate == RXP_FWD) && !trunc_any;
    push      = wr_fire && !st.hold && st.pass;
  end

  // Register access, error capture and frame tracking
  always_comb begin
    next_st = st;
    pkt_err  = PKT_DONE && (PKT_LEN_ERR || PKT_PAYLOAD_CHECK_FAIL_FLAG || st.pkt_bad);
    rd_flags = REG_RD && (REG_ADDR == ERR_FLAGS_ADDR);
    rd_tally = REG_RD && (REG_ADDR == ERR_COUNT_ADDR);
    // Read data; unmapped offsets read as zero
    case (REG_ADDR)
      MAILBOX_A_ADDR: next_st.rdata = st.mbox_a;
      MAILBOX_B_ADDR: next_st.rdata = st.mbox_b;
      ERR_FLAGS_ADDR: next_st.rdata = {4'h0, st.flags};
      ERR_COUNT_ADDR: next_st.rdata = st.tally;
      FRAME_CFG_ADDR: next_st.rdata = st.cfg;
      default:        next_st.rdata = 8'h00;
    endcase
    if (!REG_RD) begin
      next_st.rdata = st.rdata;
    end
    // Writes; mailboxes carry no function of their own
    if (REG_WR && REG_ADDR == MAILBOX_A_ADDR) next_st.mbox_a = REG_WDATA;
    if (REG_WR && REG_ADDR == MAILBOX_B_ADDR) next_st.mbox_b = REG_WDATA;
    if (REG_WR && REG_ADDR == FRAME_CFG_ADDR) next_st.cfg = REG_WDATA;
    // Clear on read first, then new events set, so a same-cycle event survives
    if (rd_flags) next_st.flags = '0;
    next_st.flags[LEN_FLAG_BIT]    = next_st.flags[LEN_FLAG_BIT]
                                     | (PKT_DONE && PKT_LEN_ERR);
    next_st.flags[CKSUM_FLAG_BIT]  = next_st.flags[CKSUM_FLAG_BIT]
                                     | (PKT_DONE && PKT_PAYLOAD_CHECK_FAIL_FLAG);
    next_st.flags[MULTI_FLAG_BIT]  = next_st.flags[MULTI_FLAG_BIT] | hdr_multi;
    next_st.flags[SINGLE_FLAG_BIT] = next_st.flags[SINGLE_FLAG_BIT] | hdr_single;
    // One count per packet, held at the top
    if (rd_tally) next_st.tally = '0;
    if (pkt_err && next_st.tally != COUNT_MAX) begin
      next_st.tally = next_st.tally + 8'h01;
    end
    // A header fault counts against the packet it opens, unless the header arrives with PKT_DONE
    if (PKT_DONE) next_st.pkt_bad = 1'b0;
    if (HDR_VALID && !PKT_DONE) next_st.pkt_bad = hdr_single || hdr_multi;
    next_st.hdr_valid = HDR_VALID && !hdr_multi;
    if (HDR_VALID) next_st.hdr = fixed;
    // Line and frame sizing
    next_st.fv_q = fv;
    next_st.lv_q = lv;
    if (RAW_VALID && lv && fv) next_st.pix = st.pix + 1'b1;
    if (lv_fall) begin
      next_st.pix_prev  = st.pix;
      next_st.have_line = 1'b1;
      next_st.pix       = '0;
      next_st.lines     = st.lines + 1'b1;
    end
    if (fv_rise) begin
      next_st.lines = '0;
      next_st.pix   = '0;
    end
    // Frame state: a truncated frame drops to its end
    case (st.fstate)
      RXP_IDLE: if (fv_rise) next_st.fstate = RXP_FWD;
      RXP_FWD: begin
        if (fv_fall) next_st.fstate = RXP_IDLE;
        else if (trunc_any) next_st.fstate = RXP_DROP;
      end
      RXP_DROP: if (fv_fall) next_st.fstate = RXP_IDLE;
      default:  next_st.fstate = RXP_IDLE;
    endcase
    if (fv_fall) begin
      next_st.lines_prev = st.lines;
      next_st.have_frame = 1'b1;
      if (st.fstate == RXP_FWD && !trunc_any && st.good != 2'h3) begin
        next_st.good = st.good + 2'h1;
      end
    end
    // Pass qualification; a frame-size cut restarts the good-frame count
    if (trunc_frame) begin
      next_st.hold = 1'b1;
      next_st.good = '0;
    end
    if (!LOCK) next_st.good = '0;
    next_st.pass = LOCK && !(trunc_frame && PASS_THRESHOLD != 2'h0)
                   && (PASS_THRESHOLD == 2'h0 || next_st.good >= PASS_THRESHOLD);
    if (st.pass && !trunc_frame) next_st.hold = 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st        <= '0;
      st.mbox_a <= MAILBOX_A_RST;
      st.mbox_b <= MAILBOX_B_RST;
      st.cfg    <= FRAME_CFG_RST;
      st.fstate <= RXP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  rxp_fifo #(.WIDTH(12), .DEPTH(DEPTH)) u_fifo (
    .clk       (REF_CLK),
    .rst_b     (RST_B),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({fv, lv, pix_out}),
    .out_valid (VID_VALID),
    .out_ready (VID_READY),
    .out_data  ({VID_FV, VID_LV, VID_DATA})
  );

  // Output drive
  assign RAW_READY     = fifo_ready;
  assign REG_RDATA     = st.rdata;
  assign HDR_OUT_VALID = st.hdr_valid;
  assign HDR_OUT       = st.hdr;
  assign PORT_PASS     = st.pass;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_flag_read;
    REG_RD && REG_ADDR == ERR_FLAGS_ADDR && !HDR_VALID && !PKT_DONE;
  endsequence
  sequence s_flags_zero;
    ##1 st.flags == 4'h0;
  endsequence

  a_mbox_reset: assert property (@(posedge REF_CLK) $rose(RST_B) |->
    st.mbox_a == 8'h00 && st.mbox_b == 8'h01) else $error("mailbox reset wrong");
  a_len_flag: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PKT_DONE && PKT_LEN_ERR |=> st.flags[3]) else $error("length flag missed");
  a_cksum_flag: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PKT_DONE && PKT_PAYLOAD_CHECK_FAIL_FLAG |=> st.flags[2]) else $error("checksum flag missed");
  a_ecc_flags: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    HDR_VALID && syn != 6'h00 |=> st.flags[1] || st.flags[0]) else $error("ecc flag missed");
  a_flag_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_flag_read |-> s_flags_zero) else $error("flags not cleared on read");
  a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    st.flags[3] && !(REG_RD && REG_ADDR == ERR_FLAGS_ADDR) |=> st.flags[3])
    else $error("flag lost without read");
  a_tally_sat: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    st.tally == 8'hFF && !rd_tally |=> st.tally == 8'hFF) else $error("tally wrapped");
  a_tally_read: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    rd_tally |=> st.tally == {7'h00, $past(pkt_err)} && REG_RDATA == $past(st.tally))
    else $error("tally read wrong");
  a_trunc_drop: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    st.fstate == RXP_FWD && trunc_par && !fv_fall |=> st.fstate == RXP_DROP [*1] ##0 !push)
    else $error("parity truncation missed");
  a_pass_lock: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    LOCK && PASS_THRESHOLD == 2'h0 |=> PORT_PASS) else $error("pass not on lock");
  a_hold_block: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    st.hold && !st.pass |-> !push) else $error("video forwarded during hold");
endmodule

`default_nettype wire

// ### tb/rxp_sensor.sv
// Behavioural remote sensor that sends raw video frames of nl lines
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rxp_sensor (
  input  wire logic  clk,
  output logic       raw_valid,
  output logic       raw_lv,
  output logic       raw_fv,
  output logic [9:0] raw_data
);
  // Idle state at time zero
  initial begin
    raw_valid = 1'b0;
    raw_lv = 1'b0;
    raw_fv = 1'b0;
    raw_data = 10'h000;
  end

  // One frame: idle, frame start, then nl lines of n pixels, each after a slow start
  task automatic send(input logic [9:0] pix, input int n, input int nl, input int gap,
                      input logic lvi, input logic fvi);
    @(posedge clk);
    raw_fv <= fvi;
    raw_lv <= lvi;
    repeat (3) @(posedge clk);
    // Frame start gets its own edge so the port never misses it
    raw_fv <= ~fvi;
    @(posedge clk);
    for (int j = 0; j < nl; j++) begin
      raw_lv <= ~lvi;
      repeat (gap) @(posedge clk);
      for (int k = 0; k < n; k++) begin
        raw_valid <= 1'b1;
        raw_data <= pix + 10'(k);
        @(posedge clk);
      end
      // Released data shows the inverse so a stale sample cannot pass
      raw_valid <= 1'b0;
      raw_data <= ~raw_data;
      raw_lv <= lvi;
      @(posedge clk);
    end
    raw_fv <= fvi;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the receive-port register group and video path
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module testbench;
  import rxp_pkg::*;
  localparam int DEPTH = 16;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        raw10 = 1'b0;
  logic        hv = 1'b0;
  logic [23:0] hw = 24'h000000;
  logic [5:0]  he = 6'h00;
  logic        done = 1'b0;
  logic        len_e = 1'b0;
  logic        ck_e = 1'b0;
  logic        vr = 1'b1;
  logic        lock = 1'b1;
  logic [1:0]  thr = 2'h0;
  logic        rmode = 1'b1;
  logic        par = 1'b0;
  logic [7:0]  rdata;
  logic        hov, vv, vfv, vlv, pass, rr, sv, slv, sfv;
  logic [23:0] ho;
  logic [9:0]  vd, sd;
  logic [11:0] got;
  logic [7:0]  v;
  int          npop = 0;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;

  rxp_port #(.DEPTH(DEPTH)) rxp_port_i (.REF_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .LOCK(lock),
    .PASS_THRESHOLD(thr), .RAW_MODE(rmode), .RAW10_MODE(raw10), .RAW_VALID(sv),
    .RAW_LV(slv), .RAW_FV(sfv), .RAW_DATA(sd), .RAW_READY(rr), .PARITY_ERR(par),
    .HDR_VALID(hv), .HDR_WORD(hw), .HDR_ECC(he), .PKT_DONE(done), .PKT_LEN_ERR(len_e),
    .PKT_PAYLOAD_CHECK_FAIL_FLAG(ck_e), .HDR_OUT_VALID(hov), .HDR_OUT(ho), .VID_VALID(vv),
    .VID_READY(vr), .VID_FV(vfv), .VID_LV(vlv), .VID_DATA(vd), .PORT_PASS(pass));
  rxp_sensor rxp_sensor_i (.clk(clk), .raw_valid(sv), .raw_lv(slv), .raw_fv(sfv),
    .raw_data(sd));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and video sink capture
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (vv && vr) begin
      got <= {vfv, vlv, vd};
      npop <= npop + 1;
    end
    if (cyc == 20000) begin
      fails++;
      $display("BAD timeout expected finish seen hang");
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared compare, register and packet tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pkt(input logic l, input logic c);
    @(posedge clk);
    done <= 1'b1;
    len_e <= l;
    ck_e <= c;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic hdr(input logic [23:0] w, input logic [5:0] e);
    @(posedge clk);
    hv <= 1'b1;
    hw <= w;
    he <= e;
    @(posedge clk);
    hv <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    // 0x7D lies outside this group and must read as zero
    for (int i = 0; i < 6; i++) begin
      rg_rd(MAILBOX_A_ADDR + 8'(i), v);
      chk("reset value", (i == 1) ? 8'h01 : 8'h00, v);
    end
    // Status and tally ignore writes
    for (int i = 0; i < 4; i++) begin
      rg_wr(MAILBOX_A_ADDR + 8'(i), 8'hA5 + 8'(i));
      rg_rd(MAILBOX_A_ADDR + 8'(i), v);
      chk("write readback", (i < 2) ? 8'hA5 + 8'(i) : 8'h00, v);
    end
    $display("test regs done");
  endtask

  task automatic t_errs;
    pkt(1'b1, 1'b1);
    hdr(24'h000001, 6'h00);
    chk("single fault fixed", 25'h1000000, {hov, ho});
    pkt(1'b0, 1'b1);
    hdr(24'h000003, 6'h00);
    chk("multi fault held", 1'b0, hov);
    // Bit 4 has column 13; one flipped check bit leaves the data alone
    hdr(24'h000010, 6'h12);
    chk("check bit fault", 25'h1000010, {hov, ho});
    rg_rd(ERR_FLAGS_ADDR, v);
    chk("flags", 8'h0F, v);
    rg_rd(ERR_FLAGS_ADDR, v);
    chk("flags cleared", 8'h00, v);
    rg_rd(ERR_COUNT_ADDR, v);
    chk("tally", 8'h02, v);
    rg_rd(ERR_COUNT_ADDR, v);
    chk("tally cleared", 8'h00, v);
    $display("test errors done");
  endtask

  task automatic t_sat;
    for (int i = 0; i < 300; i++) pkt(1'b1, 1'b0);
    // Clearing read and a new bad packet on the same edge
    @(posedge clk);
    addr <= ERR_COUNT_ADDR;
    rd <= 1'b1;
    done <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    done <= 1'b0;
    #1 chk("tally saturated", COUNT_MAX, rdata);
    rg_rd(ERR_COUNT_ADDR, v);
    chk("tally kept", 8'h01, v);
    rg_rd(ERR_FLAGS_ADDR, v);
    chk("length flag", 8'h08, v);
    $display("test saturation done");
  endtask

  task automatic t_video;
    logic [7:0] cf [4] = '{8'h80, 8'h80, 8'hC0, 8'h43};
    logic [9:0] ex;
    int         n;
    // Datatype code update lives outside this block
    for (int i = 0; i < 4; i++) begin
      raw10 <= (i > 0);
      rg_wr(FRAME_CFG_ADDR, cf[i]);
      rg_rd(FRAME_CFG_ADDR, v);
      chk("config readback", cf[i], v);
      ex = (i == 1) ? 10'h0B5 : (i == 2) ? 10'h0D5 : 10'h2D5;
      n = npop;
      rxp_sensor_i.send(10'h2D5, 1, 1, i, cf[i][LV_INV_BIT], cf[i][FV_INV_BIT]);
      repeat (4) @(posedge clk);
      chk("pixel count", n + 1, npop);
      chk("video word", {2'b11, ex}, got);
    end
    chk("pass on lock", 1'b1, pass);
    // Outside raw mode the polarity bits must not invert the sensor's levels
    rmode <= 1'b0;
    rg_wr(FRAME_CFG_ADDR, 8'h03);
    n = npop;
    rxp_sensor_i.send(10'h2D5, 1, 1, 1, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    chk("polarity off raw", n + 1, npop);
    rmode <= 1'b1;
    $display("test video done");
  endtask

  task automatic t_fifo;
    int n;
    raw10 <= 1'b0;
    rg_wr(FRAME_CFG_ADDR, FRAME_CFG_RST);
    vr <= 1'b0;
    n = npop;
    // Sink stalls while the line overfills the buffer
    rxp_sensor_i.send(10'h100, DEPTH + 2, 1, 0, 1'b0, 1'b0);
    chk("ready when full", 1'b0, rr);
    vr <= 1'b1;
    repeat (DEPTH + 4) @(posedge clk);
    chk("drained", n + DEPTH, npop);
    chk("last word", {2'b11, 10'h10F}, got);
    chk("empty", 1'b0, vv);
    $display("test fifo done");
  endtask

  task automatic t_par;
    int n;
    // Parity pulse lands on the third pixel of a four-pixel line
    for (int i = 0; i < 2; i++) begin
      rg_wr(FRAME_CFG_ADDR, (i == 0) ? 8'h00 : 8'h20);
      n = npop;
      fork
        rxp_sensor_i.send(10'h040, 4, 1, 0, 1'b0, 1'b0);
        begin
          repeat (7) @(posedge clk);
          par <= 1'b1;
          @(posedge clk);
          par <= 1'b0;
        end
      join
      repeat (3) @(posedge clk);
      chk("parity frame count", n + ((i == 0) ? 4 : 2), npop);
    end
    $display("test parity done");
  endtask

  task automatic t_line;
    int n;
    // First line differs from the last four-pixel line, so its frame is cut
    rg_wr(FRAME_CFG_ADDR, 8'h10);
    for (int i = 0; i < 2; i++) begin
      n = npop;
      rxp_sensor_i.send(10'h0A0, 2, 2, 0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      chk("line cut count", n + ((i == 0) ? 2 : 4), npop);
    end
    $display("test line size done");
  endtask

  task automatic t_pass;
    // Lock loss clears the good-frame count; one good frame then meets threshold 1
    rg_wr(FRAME_CFG_ADDR, 8'h00);
    lock <= 1'b0;
    thr <= 2'h1;
    repeat (2) @(posedge clk);
    chk("pass without lock", 1'b0, pass);
    lock <= 1'b1;
    repeat (2) @(posedge clk);
    chk("pass below threshold", 1'b0, pass);
    rxp_sensor_i.send(10'h155, 1, 1, 0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk("pass after threshold", 1'b1, pass);
    $display("test pass done");
  endtask

  task automatic t_frame;
    int n;
    // Two-line reference frame, then a three-line frame is cut
    rg_wr(FRAME_CFG_ADDR, 8'h00);
    rxp_sensor_i.send(10'h111, 1, 2, 0, 1'b0, 1'b0);
    rg_wr(FRAME_CFG_ADDR, 8'h08);
    rxp_sensor_i.send(10'h111, 1, 3, 0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk("pass dropped on cut", 1'b0, pass);
    n = npop;
    rxp_sensor_i.send(10'h111, 1, 3, 0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk("held after cut", n, npop);
    chk("pass regained", 1'b1, pass);
    n = npop;
    rxp_sensor_i.send(10'h111, 1, 3, 0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk("resumed after pass", n + 3, npop);
    $display("test frame size done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_errs();
    t_sat();
    t_video();
    t_fifo();
    t_par();
    t_line();
    t_pass();
    t_frame();
    final_report();
  end
endmodule
`default_nettype wire
